// ===== design/rtcs_pkg.sv
// Purpose: Shared constants and types of the two-wire slave port of the clock chip.
// Assumes: 20 MHz system clock; word addresses are one byte wide.
// Notes: The write-path word packs the word address above the data byte.
package rtcs_pkg;

  // System clock
  localparam int unsigned CLK_HZ = 20_000_000;

  // Byte and address widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned WORD_W = ADDR_W + DATA_W;
  localparam int unsigned ID_W = 7;

  // Register array bounds; the read pointer wraps from the last location to the first
  localparam logic [7:0] LOC_FIRST = 8'h00;
  localparam logic [7:0] LOC_LAST = 8'h19;

  // Bit counter limits within a byte
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Both bus lines idle high; synchroniser reset value
  localparam logic [2:0] LINES_IDLE = 3'h7;

  // Direction bit value that asks for a read
  localparam logic DIR_READ = 1'b1;

  // Cycles after reset during which a start is disregarded
  localparam int unsigned PWRUP_W = 8;
  localparam logic [7:0] PWRUP_CYCLES = 8'h10;

  // Entries of the write-path buffer
  localparam int unsigned WR_DEPTH = 2;

  // Transaction states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_WORD = 4'h3,
    ST_ACK_WORD = 4'h4,
    ST_DATA = 4'h5,
    ST_ACK_DATA = 4'h6,
    ST_TX = 4'h7,
    ST_MACK = 4'h8,
    ST_WAIT = 4'h9
  } rtcs_state_e;

endpackage

// ===== design/rtcs_wr_if.sv
// Purpose: Valid/ready carrier for register-array write words.
// Assumes: One clock domain on both ends.
// Notes: word holds the address in the upper byte, the data in the lower.
`timescale 1ns/1ns
interface rtcs_wr_if;
  import rtcs_pkg::*;

  logic valid;
  logic ready;
  logic [WORD_W-1:0] word;

  // Producer side
  modport src (
    output valid,
    output word,
    input ready
  );

  // Consumer side
  modport snk (
    input valid,
    input word,
    output ready
  );
endinterface

// ===== design/rtcs_fifo2.sv
// Purpose: Small valid/ready buffer on the write path to the register array.
// Assumes: Same clock on both sides; srst synchronous, active high.
// Notes: Depth and width shape the storage; full and empty follow the entry count.
`timescale 1ns/1ns
module rtcs_fifo2 #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clock, // System clock
  input wire logic srst, // Synchronous reset
  rtcs_wr_if.snk inP, // Filling side
  rtcs_wr_if.src outP // Draining side
);
  localparam int unsigned IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [IW:0] CNT_FULL = (IW + 1)'(DEPTH);
  localparam logic [IW-1:0] IDX_LAST = IW'(DEPTH - 1);
  localparam logic [IW-1:0] IDX_ZERO = '0;
  localparam logic [IW:0] CNT_ZERO = '0;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [IW-1:0] wrIdx_r, wrIdx_nxt, rdIdx_r, rdIdx_nxt;
  logic [IW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Honest full and empty from the count
  assign inP.ready = (cnt_r != CNT_FULL);
  assign outP.valid = (cnt_r != CNT_ZERO);
  assign outP.word = mem_r[rdIdx_r];
  assign push = inP.valid & inP.ready;
  assign pop = outP.valid & outP.ready;

  // Next pointers, count and storage
  always_comb
  begin
    mem_nxt = mem_r;
    wrIdx_nxt = wrIdx_r;
    rdIdx_nxt = rdIdx_r;
    cnt_nxt = cnt_r;
    if (push)
    begin
      mem_nxt[wrIdx_r] = inP.word;
      wrIdx_nxt = (wrIdx_r == IDX_LAST) ? IDX_ZERO : IW'(wrIdx_r + 1'b1);
    end
    if (pop)
      rdIdx_nxt = (rdIdx_r == IDX_LAST) ? IDX_ZERO : IW'(rdIdx_r + 1'b1);
    if (push && !pop)
      cnt_nxt = (IW + 1)'(cnt_r + 1'b1);
    else if (pop && !push)
      cnt_nxt = (IW + 1)'(cnt_r - 1'b1);
  end

  // Register stage; storage needs no reset since empty hides it
  always_ff @(posedge clock)
  begin
    mem_r <= mem_nxt;
    if (srst)
    begin
      wrIdx_r <= IDX_ZERO;
      rdIdx_r <= IDX_ZERO;
      cnt_r <= CNT_ZERO;
    end
    else
    begin
      wrIdx_r <= wrIdx_nxt;
      rdIdx_r <= rdIdx_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ===== design/rtcs_i2c_slave_port.sv
// Purpose: Two-wire slave port giving a bus master byte access to the clock register array.
// Assumes: SCL and SDA are sampled by a 20 MHz clock, several samples per SCL phase.
// Notes: SDA is open drain; sdaOut is always low and sdaOe_n low means pulling the line.
// Behaviour
// - Every byte on the link moves most significant bit first.
// - SDA changes only with SCL low; changes with SCL high mark start or stop.
// - After power-up the data line is released until a transfer needs it.
// - Bus is ignored until a start; starts during power-up are disregarded.
// - Master ends each transfer with a stop; device then returns to idle.
// - Sender releases SDA after eight bits; receiver pulls low on the ninth.
// - Device acknowledges valid slave address, word address and each written data byte the write buffer has room for.
// - First byte: seven identifier bits, then direction bit, one meaning read.
// - Seven identifier bits of the slave byte compared with the fixed code; acknowledge only on match.
// - One word address byte follows, or the internal counter supplies it.
// - Address counter starts at location zero after power-up.
// - Write: start, slave byte, word address, one data byte, stop; all acknowledged.
// - Device sends bytes while the master acknowledges; master then issues stop.
// - Read data come from a pointer loaded by the address, advancing per byte.
// - Pointer wraps from the last location to zero and transmission continues.
`timescale 1ns/1ns
module rtcs_i2c_slave_port
  import rtcs_pkg::*;
#(
  parameter logic [ID_W-1:0] DEV_ID = 7'h2A, // Arbitrary value
  parameter logic [PWRUP_W-1:0] POWERUP_CYCLES = PWRUP_CYCLES
) (
  input wire logic clock, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic sclIn, // Serial clock pin level
  input wire logic sdaIn, // Serial data pin level
  output logic sdaOut, // Serial data drive value
  output logic sdaOe_n, // Low while pulling SDA
  output logic [rtcs_pkg::ADDR_W-1:0] rdAddr, // Read pointer into the array
  input wire logic [rtcs_pkg::DATA_W-1:0] rdData, // Array byte at rdAddr
  output logic wrValid, // Write word available
  input wire logic wrReady, // Array takes the word
  output logic [rtcs_pkg::ADDR_W-1:0] wrAddr, // Write location
  output logic [rtcs_pkg::DATA_W-1:0] wrData // Write byte
);
  import rtcs_pkg::*;

  rtcs_wr_if inIf ();
  rtcs_wr_if outIf ();

  rtcs_state_e state_r, state_nxt;
  logic [2:0] sclQ_r, sclQ_nxt, sdaQ_r, sdaQ_nxt;
  logic [DATA_W-1:0] shift_r, shift_nxt;
  logic [2:0] bitCnt_r, bitCnt_nxt;
  logic byteDone_r, byteDone_nxt;
  logic isRead_r, isRead_nxt;
  logic masterAck_r, masterAck_nxt;
  logic sdaOe_n_r, sdaOe_n_nxt;
  logic [ADDR_W-1:0] ptr_r, ptr_nxt;
  logic [PWRUP_W-1:0] puCnt_r, puCnt_nxt;
  logic puDone_r, puDone_nxt;
  logic pushValid;
  logic sclHi, sclRise, sclFall, startEv, stopEv, idMatch;

  // Pointer advance with wrap at the top of the array
  function automatic logic [ADDR_W-1:0] nextLoc(input logic [ADDR_W-1:0] p);
    nextLoc = (p == LOC_LAST) ? LOC_FIRST : ADDR_W'(p + 1'b1);
  endfunction

  // Line events use only the second and third sync stages
  assign sclHi = sclQ_r[1];
  assign sclRise = sclQ_r[1] & ~sclQ_r[2];
  assign sclFall = ~sclQ_r[1] & sclQ_r[2];
  assign startEv = sclQ_r[1] & sclQ_r[2] & sdaQ_r[2] & ~sdaQ_r[1];
  assign stopEv = sclQ_r[1] & sclQ_r[2] & ~sdaQ_r[2] & sdaQ_r[1];
  assign idMatch = (shift_r[DATA_W-1:1] == DEV_ID);

  // Open-drain pin: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe_n = sdaOe_n_r;
  assign rdAddr = ptr_r;

  // Write path through the buffer; the array may stall
  assign inIf.valid = pushValid;
  assign inIf.word = {ptr_r, shift_r};
  assign outIf.ready = wrReady;
  assign wrValid = outIf.valid;
  assign wrAddr = outIf.word[WORD_W-1:DATA_W];
  assign wrData = outIf.word[DATA_W-1:0];

  rtcs_fifo2 #(
    .WIDTH(WORD_W),
    .DEPTH(WR_DEPTH)
  ) rtcs_fifo2_inst (
    .clock(clock),
    .srst(srst),
    .inP(inIf.snk),
    .outP(outIf.src)
  );

  // Synchronisers and power-up hold-off
  always_comb
  begin
    sclQ_nxt = {sclQ_r[1:0], sclIn};
    sdaQ_nxt = {sdaQ_r[1:0], sdaIn};
    puCnt_nxt = puCnt_r;
    puDone_nxt = puDone_r;
    if (!puDone_r)
    begin
      puCnt_nxt = PWRUP_W'(puCnt_r + 1'b1);
      puDone_nxt = (puCnt_nxt >= POWERUP_CYCLES);
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      sclQ_r <= LINES_IDLE;
      sdaQ_r <= LINES_IDLE;
      puCnt_r <= '0;
      puDone_r <= 1'b0;
    end
    else
    begin
      sclQ_r <= sclQ_nxt;
      sdaQ_r <= sdaQ_nxt;
      puCnt_r <= puCnt_nxt;
      puDone_r <= puDone_nxt;
    end
  end

  // Transaction sequencer; stop and start override every state
  always_comb
  begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    bitCnt_nxt = bitCnt_r;
    byteDone_nxt = byteDone_r;
    isRead_nxt = isRead_r;
    masterAck_nxt = masterAck_r;
    sdaOe_n_nxt = sdaOe_n_r;
    ptr_nxt = ptr_r;
    pushValid = 1'b0;
    if (stopEv)
    begin
      state_nxt = ST_IDLE;
      sdaOe_n_nxt = 1'b1;
      byteDone_nxt = 1'b0;
    end
    else if (startEv && puDone_r)
    begin
      state_nxt = ST_ADDR;
      sdaOe_n_nxt = 1'b1;
      bitCnt_nxt = BIT_FIRST;
      byteDone_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        ST_ADDR, ST_WORD, ST_DATA:
        begin
          if (sclRise)
          begin
            shift_nxt = {shift_r[DATA_W-2:0], sdaQ_r[1]};
            bitCnt_nxt = 3'(bitCnt_r + 1'b1);
            byteDone_nxt = (bitCnt_r == BIT_LAST);
          end
          else if (sclFall && byteDone_r)
          begin
            byteDone_nxt = 1'b0;
            if (state_r == ST_ADDR)
            begin
              if (idMatch)
              begin
                sdaOe_n_nxt = 1'b0;
                isRead_nxt = (shift_r[0] == DIR_READ);
                state_nxt = ST_ACK_ADDR;
              end
              else
                state_nxt = ST_WAIT;
            end
            else if (state_r == ST_WORD)
            begin
              ptr_nxt = shift_r;
              sdaOe_n_nxt = 1'b0;
              state_nxt = ST_ACK_WORD;
            end
            else if (inIf.ready)
            begin
              // A full buffer refuses the byte rather than losing it
              pushValid = 1'b1;
              ptr_nxt = nextLoc(ptr_r);
              sdaOe_n_nxt = 1'b0;
              state_nxt = ST_ACK_DATA;
            end
            else
              state_nxt = ST_WAIT;
          end
        end
        ST_ACK_ADDR:
        begin
          if (sclFall)
          begin
            bitCnt_nxt = BIT_FIRST;
            if (isRead_r)
            begin
              // Current-address or random read starts at the pointer
              shift_nxt = rdData;
              sdaOe_n_nxt = rdData[DATA_W-1];
              state_nxt = ST_TX;
            end
            else
            begin
              sdaOe_n_nxt = 1'b1;
              state_nxt = ST_WORD;
            end
          end
        end
        ST_ACK_WORD:
        begin
          if (sclFall)
          begin
            sdaOe_n_nxt = 1'b1;
            state_nxt = ST_DATA;
          end
        end
        ST_ACK_DATA:
        begin
          if (sclFall)
          begin
            sdaOe_n_nxt = 1'b1;
            state_nxt = ST_WAIT;
          end
        end
        ST_TX:
        begin
          if (sclFall)
          begin
            if (bitCnt_r == BIT_LAST)
            begin
              // Release for the master's acknowledge; pointer moves on now
              sdaOe_n_nxt = 1'b1;
              ptr_nxt = nextLoc(ptr_r);
              state_nxt = ST_MACK;
            end
            else
            begin
              shift_nxt = {shift_r[DATA_W-2:0], 1'b0};
              sdaOe_n_nxt = shift_r[DATA_W-2];
              bitCnt_nxt = 3'(bitCnt_r + 1'b1);
            end
          end
        end
        ST_MACK:
        begin
          if (sclRise)
            masterAck_nxt = ~sdaQ_r[1];
          else if (sclFall)
          begin
            bitCnt_nxt = BIT_FIRST;
            if (masterAck_r)
            begin
              shift_nxt = rdData;
              sdaOe_n_nxt = rdData[DATA_W-1];
              state_nxt = ST_TX;
            end
            else
              state_nxt = ST_WAIT;
          end
        end
        ST_IDLE, ST_WAIT:
          sdaOe_n_nxt = 1'b1;
        default:
        begin
          state_nxt = ST_IDLE;
          sdaOe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_r <= ST_IDLE;
      shift_r <= '0;
      bitCnt_r <= BIT_FIRST;
      byteDone_r <= 1'b0;
      isRead_r <= 1'b0;
      masterAck_r <= 1'b0;
      sdaOe_n_r <= 1'b1;
      ptr_r <= LOC_FIRST;
    end
    else
    begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      bitCnt_r <= bitCnt_nxt;
      byteDone_r <= byteDone_nxt;
      isRead_r <= isRead_nxt;
      masterAck_r <= masterAck_nxt;
      sdaOe_n_r <= sdaOe_n_nxt;
      ptr_r <= ptr_nxt;
    end
  end

  // Checks on the sequencer
  property p_reset_state;
    @(posedge clock) disable iff (srst)
    $fell(srst) |-> sdaOe_n_r && ptr_r == LOC_FIRST;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

  property p_pwrup_ignore;
    @(posedge clock) disable iff (srst)
    !puDone_r |-> state_r == ST_IDLE && sdaOe_n_r;
  endproperty
  a_pwrup_ignore: assert property (p_pwrup_ignore) else $error("start taken in power-up");

  property p_start_addr;
    @(posedge clock) disable iff (srst)
    startEv && puDone_r && !stopEv |=> state_r == ST_ADDR && bitCnt_r == BIT_FIRST;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");

  property p_stop_idle;
    @(posedge clock) disable iff (srst)
    stopEv |-> ##1 (state_r == ST_IDLE && sdaOe_n_r);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");

  property p_id_ack;
    @(posedge clock) disable iff (srst)
    state_r == ST_ADDR && sclFall && byteDone_r && idMatch && !startEv && !stopEv
      |=> state_r == ST_ACK_ADDR && !sdaOe_n_r;
  endproperty
  a_id_ack: assert property (p_id_ack) else $error("matching id not acked");

  property p_id_nack;
    @(posedge clock) disable iff (srst)
    state_r == ST_ADDR && sclFall && byteDone_r && !idMatch && !startEv && !stopEv
      |=> state_r == ST_WAIT && sdaOe_n_r;
  endproperty
  a_id_nack: assert property (p_id_nack) else $error("mismatched id drove SDA");

  property p_edge_low;
    @(posedge clock) disable iff (srst)
    !$stable(sdaOe_n_r) && state_r != ST_IDLE && state_r != ST_ADDR |-> !$past(sclHi);
  endproperty
  a_edge_low: assert property (p_edge_low) else $error("SDA moved with SCL high");

  property p_push_ack;
    @(posedge clock) disable iff (srst)
    pushValid |=> state_r == ST_ACK_DATA && !sdaOe_n_r ##1 !sdaOe_n_r;
  endproperty
  a_push_ack: assert property (p_push_ack) else $error("data byte not acked");

  property p_ptr_wrap;
    @(posedge clock) disable iff (srst)
    state_r == ST_TX && sclFall && bitCnt_r == BIT_LAST && ptr_r == LOC_LAST && !startEv
      && !stopEv |=> ptr_r == LOC_FIRST && state_r == ST_MACK;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

  property p_ptr_step;
    @(posedge clock) disable iff (srst)
    state_r == ST_TX && sclFall && bitCnt_r == BIT_LAST && ptr_r != LOC_LAST && !startEv
      && !stopEv |=> ptr_r == ADDR_W'($past(ptr_r) + 1'b1);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance");

  property p_msb_first;
    @(posedge clock) disable iff (srst)
    state_r == ST_ACK_ADDR && isRead_r && sclFall && !startEv && !stopEv
      |=> sdaOe_n_r == $past(rdData[DATA_W-1]) && state_r == ST_TX;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first read bit not MSB");
endmodule

// ===== sim/rtcs_bus_master.sv
// Purpose: Two-wire bus master model that drives the slave port from the far side.
// Assumes: SCL period of 8 system clocks (400 ns); line pulled up when released.
// Notes: sdaOut high releases the line; SCL stands high between frames.
`timescale 1ns/1ns
module rtcs_bus_master (
  input wire logic clock, // System clock pacing the bus
  input wire logic sdaLine, // Resolved data line
  output logic sclOut, // Serial clock to the device
  output logic sdaOut // Data drive, high releases
);
  // Bus idles released with the clock parked high
  initial
  begin
    sclOut = 1'b1;
    sdaOut = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One clock pulse; data set up early in the low phase, line sampled mid-high
  task automatic pulse(input logic bitVal, output logic seen);
    wait_clk(1);
    sdaOut <= bitVal;
    wait_clk(3);
    sclOut <= 1'b1;
    wait_clk(2);
    seen = sdaLine;
    wait_clk(2);
    sclOut <= 1'b0;
  endtask

  // Start or repeated start; data falls only while the clock is high
  task automatic start_cond();
    wait_clk(1);
    sdaOut <= 1'b1;
    wait_clk(3);
    sclOut <= 1'b1;
    wait_clk(4);
    sdaOut <= 1'b0;
    wait_clk(4);
    sclOut <= 1'b0;
  endtask

  // Stop leaves both lines high, so the clock stands still until the next frame
  task automatic stop_cond();
    wait_clk(1);
    sdaOut <= 1'b0;
    wait_clk(3);
    sclOut <= 1'b1;
    wait_clk(4);
    sdaOut <= 1'b1;
    wait_clk(4);
  endtask

  // Eight bits out, then the line is released for the slave's acknowledge
  task automatic send_byte(input logic [7:0] b, output logic nack);
    logic seen;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(b[i], seen);
    end
    pulse(1'b1, nack);
  endtask

  // Eight bits in; low in the ninth clock asks for another byte
  task automatic read_byte(input logic nackIn, output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(1'b1, seen);
      b[i] = seen;
    end
    pulse(nackIn, seen);
  endtask
endmodule

// ===== sim/tb_rtcs_i2c_slave_port.sv
// Purpose: Self-checking bench for the two-wire slave port.
// Assumes: 50 ns system clock; array model answers reads at once.
// Notes: Array holds 40h plus the location at start; writes land through the buffer.
`timescale 1ns/1ns
module tb_rtcs_i2c_slave_port;
  import rtcs_pkg::*;
  localparam logic [6:0] ID = 7'h2A; // Arbitrary value
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic wrReady = 1'b1;
  logic sclPin, sdaM, sdaOut, sdaOe_n, wrValid;
  wire logic sdaLine;
  logic [7:0] rdAddr, rdData, wrAddr, wrData;
  logic [7:0] mem [0:25];
  logic [15:0] wq [$];
  int errTotal = 0;
  int comparisons = 0;

  // Open-drain line with pull-up: low whenever any party pulls
  assign sdaLine = sdaM & (sdaOe_n ? 1'b1 : sdaOut);
  assign rdData = (rdAddr <= LOC_LAST) ? mem[rdAddr] : 8'hEE;

  rtcs_bus_master rtcs_bus_master_inst (
    .clock(clock), .sdaLine(sdaLine), .sclOut(sclPin), .sdaOut(sdaM));

  rtcs_i2c_slave_port #(.DEV_ID(ID), .POWERUP_CYCLES(PWRUP_CYCLES)) rtcs_i2c_slave_port_inst (
    .clock(clock), .srst(srst), .sclIn(sclPin), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .rdAddr(rdAddr), .rdData(rdData), .wrValid(wrValid),
    .wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData));

  // Clock generator
  initial
  begin
    forever #25 clock = ~clock;
  end

  // Array model takes a word whenever both sides agree
  always @(posedge clock)
  begin
    if (wrValid === 1'b1 && wrReady === 1'b1)
    begin
      mem[wrAddr] <= wrData;
      wq.push_back({wrAddr, wrData});
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Full write frame; the data byte's answer is given by the caller
  task automatic write_txn(input logic [7:0] a, input logic [7:0] d, input logic dNack);
    logic nack;
    rtcs_bus_master_inst.start_cond();
    rtcs_bus_master_inst.send_byte({ID, 1'b0}, nack);
    check(nack, 1'b0);
    rtcs_bus_master_inst.send_byte(a, nack);
    check(nack, 1'b0);
    rtcs_bus_master_inst.send_byte(d, nack);
    check(nack, dNack);
    rtcs_bus_master_inst.stop_cond();
  endtask

  // Current read straight after power-up starts at location zero
  task automatic test_current_read();
    logic nack;
    logic [7:0] b;
    check(sdaOe_n, 1'b1);
    check(rdAddr, 8'h00);
    rtcs_bus_master_inst.start_cond();
    rtcs_bus_master_inst.send_byte({ID, 1'b1}, nack);
    check(nack, 1'b0);
    rtcs_bus_master_inst.read_byte(1'b1, b);
    check(b, 8'h40);
    rtcs_bus_master_inst.stop_cond();
    check(rdAddr, 8'h01);
    $display("test current read done");
  endtask

  // Single write reaches the array as one word
  task automatic test_write();
    write_txn(8'h05, 8'hA5, 1'b0);
    repeat (6) @(posedge clock);
    check(wq.pop_front(), 16'h05A5);
    $display("test write done");
  endtask

  // Random read across the top of the array wraps to zero
  task automatic test_read_wrap();
    logic nack;
    logic [7:0] b;
    rtcs_bus_master_inst.start_cond();
    rtcs_bus_master_inst.send_byte({ID, 1'b0}, nack);
    check(nack, 1'b0);
    rtcs_bus_master_inst.send_byte(8'h18, nack);
    check(nack, 1'b0);
    rtcs_bus_master_inst.start_cond();
    rtcs_bus_master_inst.send_byte({ID, 1'b1}, nack);
    check(nack, 1'b0);
    rtcs_bus_master_inst.read_byte(1'b0, b);
    check(b, 8'h58);
    rtcs_bus_master_inst.read_byte(1'b0, b);
    check(b, 8'h59);
    rtcs_bus_master_inst.read_byte(1'b1, b);
    check(b, 8'h40);
    check(sdaOe_n, 1'b1);
    rtcs_bus_master_inst.stop_cond();
    $display("test read wrap done");
  endtask

  // Foreign identifier is never acknowledged and nothing follows
  task automatic test_bad_id();
    logic nack;
    rtcs_bus_master_inst.start_cond();
    rtcs_bus_master_inst.send_byte({ID ^ 7'h01, 1'b0}, nack);
    check(nack, 1'b1);
    rtcs_bus_master_inst.send_byte(8'h00, nack);
    check(nack, 1'b1);
    rtcs_bus_master_inst.stop_cond();
    $display("test bad id done");
  endtask

  // Stalled array: two words fit, the third data byte is refused
  task automatic test_buffer_full();
    @(posedge clock);
    wrReady <= 1'b0;
    write_txn(8'h10, 8'h11, 1'b0);
    write_txn(8'h11, 8'h22, 1'b0);
    write_txn(8'h12, 8'h33, 1'b1);
    check(wrValid, 1'b1);
    wrReady <= 1'b1;
    repeat (8) @(posedge clock);
    check(wq.pop_front(), 16'h1011);
    check(wq.pop_front(), 16'h1122);
    check(16'(wq.size()), 16'h0000);
    check(wrValid, 1'b0);
    $display("test buffer full done");
  endtask

  // A start inside the power-up hold-off after a second reset is ignored
  task automatic test_powerup_start();
    logic nack;
    srst <= 1'b1;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    rtcs_bus_master_inst.start_cond();
    rtcs_bus_master_inst.send_byte({ID, 1'b1}, nack);
    check(nack, 1'b1);
    check(rdAddr, 8'h00);
    rtcs_bus_master_inst.stop_cond();
    $display("test powerup start done");
  endtask

  // Main sequence
  initial
  begin
    for (int i = 0; i < 26; i++)
    begin
      mem[i] = 8'h40 + 8'(i);
    end
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    repeat (int'(PWRUP_CYCLES) + 4) @(posedge clock);
    test_current_read();
    test_write();
    test_read_wrap();
    test_bad_id();
    test_buffer_full();
    test_powerup_start();
    complete_run();
  end

  // Watchdog sized well above the roughly 1900 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clock);
    errTotal++;
    $display("watchdog expired");
    complete_run();
  end
endmodule
